// ==== core/urc_pkg.sv ====
// Purpose: Shared constants and carriers of the report command handler
// Assumes: 64-byte reports arrive and leave as byte streams
// Notes: Storage, serial engines and pin pads sit outside the handler
`default_nettype none
package urc_pkg;
    localparam int REP_LEN = 64;
    localparam int B_WDATA = 4;
    localparam int R_DATA = 3;
    localparam logic [7:0] OP_PIN_RD = 8'h30;
    localparam logic [7:0] OP_PIN_WR = 8'h31;
    localparam logic [7:0] OP_PIN_IF = 8'h32;
    localparam logic [7:0] OP_DFLT = 8'h41;
    localparam logic [7:0] OP_LOADER = 8'h42;
    localparam logic [7:0] OP_SER_CFG = 8'h51;
    localparam logic [7:0] OP_BRIDGE = 8'h52;
    localparam logic [7:0] OP_RESET = 8'h55;
    localparam logic [7:0] OP_VERSION = 8'h61;
    localparam logic [7:0] ST_ERR = 8'h00;
    localparam logic [7:0] ST_OK = 8'h01;
    localparam logic [7:0] ST_NO_MASTER = 8'h02;
    localparam logic [7:0] ST_BUS_ERR = 8'h03;
    localparam logic [7:0] VAL_OFF = 8'h00;
    localparam logic [7:0] VAL_ON = 8'h01;
    localparam logic [7:0] PORT_MIN = 8'h01;
    localparam logic [7:0] PORT_MAX = 8'h03;
    localparam logic [7:0] ACT_SLAVE = 8'h01;
    localparam logic [7:0] ACT_MASTER = 8'h02;
    localparam logic [7:0] ACT_ADDR = 8'h03;
    localparam logic [7:0] BR_WRITE = 8'h01;
    localparam logic [7:0] BR_READ = 8'h02;
    localparam logic [7:0] BR_WR_MAX = 8'h3c;
    localparam logic [7:0] BR_RD_MAX = 8'h3d;
    localparam logic [7:0] SUBJ_FW = 8'h01;
    localparam logic [7:0] SUBJ_LDR = 8'h02;
    localparam logic [7:0] SW_ON_BASE = 8'h03;
    localparam logic [7:0] SW_OFF_BASE = 8'h07;
    localparam logic [7:0] SW_ALL_ON = 8'h0b;
    localparam logic [7:0] SW_ALL_OFF = 8'h0c;
    localparam logic [7:0] FACTORY_ADDR = 8'ha6;
    typedef struct packed {
        logic [2:0] dflt;
        logic slave_en;
        logic master_en;
        logic [7:0] slave_addr;
    } urc_cfg_s;
    localparam urc_cfg_s CFG_FACTORY = '{dflt: 3'h0, slave_en: 1'b0, master_en: 1'b0,
                                         slave_addr: FACTORY_ADDR};
    typedef struct packed {
        logic rd;
        logic [6:0] addr;
        logic [7:0] len;
    } urc_br_req_s;
    typedef struct packed {
        logic [7:0] major;
        logic [7:0] minor;
        logic [7:0] patch;
    } urc_ver_s;
endpackage
`default_nettype wire

// ==== core/urc_cmd_handler.sv ====
// Purpose: Decode 64-byte command reports and build one reply report each
// Assumes: Storage, bridge engine and slave engine run on ref_clk
// Notes: Version values are arbitrary parameters
`default_nettype none
module urc_cmd_handler #(
    parameter urc_pkg::urc_ver_s FW_VER = '{major: 8'h01, minor: 8'h00, patch: 8'h00},
    parameter urc_pkg::urc_ver_s LDR_VER = '{major: 8'h01, minor: 8'h00, patch: 8'h00}
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Command report stream
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_data,
    // Reply report stream
    output logic rep_valid,
    input wire logic rep_ready,
    output logic [7:0] rep_data,
    // Non-volatile settings
    input wire urc_pkg::urc_cfg_s nv_cfg_in,
    input wire logic nv_blank,
    output logic nv_wr,
    output urc_pkg::urc_cfg_s nv_cfg_out,
    // Board controls
    output logic [2:0] port_on,
    output logic gpio_if_en,
    output logic loader_mode,
    output logic sys_reset_req,
    // Serial interface configuration
    output logic slave_en,
    output logic master_en,
    output logic [7:0] slave_addr,
    // Serial slave switch requests
    input wire logic slv_cmd_valid,
    input wire logic [7:0] slv_cmd_code,
    // Serial bridge engine
    output logic br_start,
    output urc_pkg::urc_br_req_s br_req,
    output logic br_wvalid,
    input wire logic br_wready,
    output logic [7:0] br_wdata,
    input wire logic br_rvalid,
    input wire logic [7:0] br_rdata,
    input wire logic br_done,
    input wire logic br_err,
    // Pins
    input wire logic [2:0] gpio_in,
    output logic [2:0] gpio_out,
    output logic [2:0] gpio_oe_n
);
    import urc_pkg::*;

    typedef enum logic [2:0] {S_LOAD, S_RX, S_EXEC, S_BR, S_TX} urc_state_e;
    typedef struct packed {
        urc_state_e state;
        logic [5:0] idx;
        logic [63:0][7:0] rbuf;
        urc_cfg_s cfg;
        logic [2:0] port_on;
        logic gpio_if_en;
        logic loader;
        logic [2:0] gp_out;
        logic [2:0] gp_drv;
        logic [2:0] gin_s1;
        logic [2:0] gin_s2;
        logic br_rd;
        logic [7:0] br_len;
        logic nv_wr;
        logic rst_req;
        logic br_start;
    } urc_st_s;
    localparam urc_st_s ST_RST = '{state: S_LOAD, cfg: CFG_FACTORY, default: '0};

    urc_st_s st_r;
    urc_st_s st_nxt;
    logic [63:0][7:0] rep;
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] c3;

    function automatic logic is_port(input logic [7:0] b);
        return (b >= PORT_MIN) && (b <= PORT_MAX);
    endfunction

    function automatic logic is_bit(input logic [7:0] b);
        return (b == VAL_OFF) || (b == VAL_ON);
    endfunction

    function automatic logic [1:0] pidx(input logic [7:0] b);
        return b[1:0] - 2'd1;
    endfunction

    // Port switch codes from the serial slave engine
    function automatic logic [2:0] slave_switch(input logic [2:0] cur, input logic [7:0] code);
        logic [2:0] r;
        r = cur;
        if (code == SW_ALL_ON)
            r = 3'h7;
        if (code == SW_ALL_OFF)
            r = 3'h0;
        for (int k = 0; k < 3; k++)
        begin
            if (code == SW_ON_BASE + 8'(k))
                r[k] = 1'b1;
            if (code == SW_OFF_BASE + 8'(k))
                r[k] = 1'b0;
        end
        return r;
    endfunction

    assign c1 = st_r.rbuf[1];
    assign c2 = st_r.rbuf[2];
    assign c3 = st_r.rbuf[3];

    // Next state of the whole handler
    always_comb
    begin
        st_nxt = st_r;
        rep = '0;
        st_nxt.nv_wr = 1'b0;
        st_nxt.rst_req = 1'b0;
        st_nxt.br_start = 1'b0;
        st_nxt.gin_s1 = gpio_in;
        st_nxt.gin_s2 = st_r.gin_s1;
        if (slv_cmd_valid && st_r.cfg.slave_en)
            st_nxt.port_on = slave_switch(st_r.port_on, slv_cmd_code);
        unique case (st_r.state)
            S_LOAD:
            begin
                st_nxt.cfg = nv_blank ? CFG_FACTORY : nv_cfg_in;
                st_nxt.port_on = st_nxt.cfg.dflt;
                st_nxt.idx = '0;
                st_nxt.state = S_RX;
            end
            S_RX:
            begin
                if (cmd_valid)
                begin
                    st_nxt.rbuf[st_r.idx] = cmd_data;
                    st_nxt.idx = st_r.idx + 6'd1;
                    if (st_r.idx == 6'd63)
                        st_nxt.state = S_EXEC;
                end
            end
            S_EXEC:
            begin
                rep[0] = ST_ERR;
                rep[1] = st_r.rbuf[0];
                case (st_r.rbuf[0])
                    OP_PIN_IF:
                    begin
                        if (is_bit(c1))
                        begin
                            st_nxt.gpio_if_en = c1[0];
                            rep[0] = ST_OK;
                        end
                        rep[2] = {7'h0, st_nxt.gpio_if_en};
                    end
                    OP_PIN_RD:
                    begin
                        if (is_port(c1))
                        begin
                            rep[0] = ST_OK;
                            rep[2] = c1;
                            rep[3] = {7'h0, st_r.gin_s2[pidx(c1)]};
                        end
                    end
                    OP_PIN_WR:
                    begin
                        if (is_port(c1) && is_bit(c2))
                        begin
                            st_nxt.gp_out[pidx(c1)] = c2[0];
                            st_nxt.gp_drv[pidx(c1)] = 1'b1;
                            rep[0] = ST_OK;
                            rep[2] = c1;
                            rep[3] = c2;
                        end
                    end
                    OP_DFLT:
                    begin
                        if (is_port(c1) && is_bit(c2))
                        begin
                            st_nxt.cfg.dflt[pidx(c1)] = c2[0];
                            st_nxt.nv_wr = 1'b1;
                            rep[0] = ST_OK;
                            rep[2] = c1;
                            rep[3] = c2;
                        end
                    end
                    OP_LOADER:
                    begin
                        st_nxt.loader = 1'b1;
                        rep[0] = ST_OK;
                    end
                    OP_SER_CFG:
                    begin
                        if ((c1 == ACT_SLAVE) && is_bit(c2))
                            st_nxt.cfg.slave_en = c2[0];
                        if ((c1 == ACT_MASTER) && is_bit(c2))
                            st_nxt.cfg.master_en = c2[0];
                        if (c1 == ACT_ADDR)
                            st_nxt.cfg.slave_addr = c2;
                        if ((((c1 == ACT_SLAVE) || (c1 == ACT_MASTER)) && is_bit(c2))
                            || (c1 == ACT_ADDR))
                        begin
                            st_nxt.nv_wr = 1'b1;
                            rep[0] = ST_OK;
                        end
                    end
                    OP_BRIDGE:
                    begin
                        if (!st_r.cfg.master_en)
                        begin
                            rep[0] = ST_NO_MASTER;
                            rep[2] = c3;
                        end
                        else if (((c1 == BR_WRITE) && (c3 <= BR_WR_MAX))
                                 || ((c1 == BR_READ) && (c3 <= BR_RD_MAX)))
                        begin
                            st_nxt.br_start = 1'b1;
                            st_nxt.br_rd = (c1 == BR_READ);
                            st_nxt.br_len = c3;
                            st_nxt.idx = '0;
                            st_nxt.state = S_BR;
                        end
                    end
                    OP_RESET:
                        rep[0] = ST_OK;
                    OP_VERSION:
                    begin
                        if ((c1 == SUBJ_FW) || (c1 == SUBJ_LDR))
                        begin
                            rep[0] = ST_OK;
                            rep[2] = (c1 == SUBJ_FW) ? FW_VER.major : LDR_VER.major;
                            rep[3] = (c1 == SUBJ_FW) ? FW_VER.minor : LDR_VER.minor;
                            rep[4] = (c1 == SUBJ_FW) ? FW_VER.patch : LDR_VER.patch;
                        end
                    end
                    default:
                        rep[0] = ST_ERR;
                endcase
                if (st_nxt.state == S_EXEC)
                begin
                    st_nxt.rbuf = rep;
                    st_nxt.idx = '0;
                    st_nxt.state = S_TX;
                end
            end
            S_BR:
            begin
                if (br_wvalid && br_wready)
                    st_nxt.idx = st_r.idx + 6'd1;
                if (st_r.br_rd && br_rvalid && ({2'b0, st_r.idx} < st_r.br_len))
                begin
                    st_nxt.rbuf[6'(R_DATA + int'(st_r.idx))] = br_rdata;
                    st_nxt.idx = st_r.idx + 6'd1;
                end
                if (br_done)
                begin
                    for (int i = R_DATA; i < REP_LEN; i++)
                        if (st_r.br_rd && (i < R_DATA + int'(st_nxt.idx)))
                            rep[i] = st_nxt.rbuf[i];
                    rep[0] = br_err ? ST_BUS_ERR : ST_OK;
                    rep[1] = OP_BRIDGE;
                    rep[2] = {2'b0, st_nxt.idx};
                    st_nxt.rbuf = rep;
                    st_nxt.idx = '0;
                    st_nxt.state = S_TX;
                end
            end
            S_TX:
            begin
                if (rep_ready)
                begin
                    st_nxt.idx = st_r.idx + 6'd1;
                    if (st_r.idx == 6'd63)
                    begin
                        st_nxt.state = S_RX;
                        if ((st_r.rbuf[1] == OP_RESET) && (st_r.rbuf[0] == ST_OK))
                        begin
                            st_nxt = ST_RST;
                            st_nxt.rst_req = 1'b1;
                        end
                    end
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            st_r <= ST_RST;
        else
            st_r <= st_nxt;
    end

    // Outputs
    assign cmd_ready = (st_r.state == S_RX);
    assign rep_valid = (st_r.state == S_TX);
    assign rep_data = st_r.rbuf[st_r.idx];
    assign nv_wr = st_r.nv_wr;
    assign nv_cfg_out = st_r.cfg;
    assign port_on = st_r.port_on;
    assign gpio_if_en = st_r.gpio_if_en;
    assign loader_mode = st_r.loader;
    assign sys_reset_req = st_r.rst_req;
    assign slave_en = st_r.cfg.slave_en;
    assign master_en = st_r.cfg.master_en;
    assign slave_addr = st_r.cfg.slave_addr;
    assign br_start = st_r.br_start;
    assign br_req = '{rd: st_r.br_rd, addr: st_r.rbuf[2][7:1], len: st_r.br_len};
    assign br_wvalid = (st_r.state == S_BR) && !st_r.br_rd && ({2'b0, st_r.idx} < st_r.br_len);
    assign br_wdata = st_r.rbuf[6'(B_WDATA + int'(st_r.idx))];
    assign gpio_out = st_r.gp_out;
    assign gpio_oe_n = ~st_r.gp_drv;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_exec(logic [7:0] op);
        (st_r.state == S_EXEC) && (st_r.rbuf[0] == op);
    endsequence
    sequence s_tx_last;
        rep_valid && rep_ready && (st_r.idx == 6'd63);
    endsequence

    a_rx_full_exec: assert property (
        cmd_valid && cmd_ready && (st_r.idx == 6'd63) |=> (st_r.state == S_EXEC)
        ##1 (rep_valid || (st_r.state == S_BR))) else $error("report not executed");
    a_single_reply: assert property (
        s_tx_last |=> !rep_valid) else $error("second reply sent");
    a_pin_if_on: assert property (
        s_exec(OP_PIN_IF) ##0 (c1 == VAL_ON) |=> gpio_if_en && (rep_data == ST_OK)
        && (st_r.rbuf[2] == 8'h01)) else $error("pin interface not enabled");
    a_pin_read: assert property (
        s_exec(OP_PIN_RD) ##0 (c1 == 8'h02) |=> (st_r.rbuf[3] == {7'h0, $past(st_r.gin_s2[1])})
        && (st_r.rbuf[1] == OP_PIN_RD)) else $error("pin read wrong");
    a_pin_write: assert property (
        s_exec(OP_PIN_WR) ##0 (c1 == 8'h03) && (c2 == VAL_ON) |=> !gpio_oe_n[2] && gpio_out[2]
        && (st_r.rbuf[3] == VAL_ON)) else $error("pin write wrong");
    a_dflt_store: assert property (
        s_exec(OP_DFLT) ##0 (c1 == 8'h01) && (c2 == VAL_ON) |=> nv_wr && nv_cfg_out.dflt[0]
        && (st_r.rbuf[0] == ST_OK)) else $error("default not stored");
    a_load_dflt: assert property (
        (st_r.state == S_LOAD) && !nv_blank |=> (port_on == $past(nv_cfg_in.dflt)) && cmd_ready)
        else $error("defaults not applied");
    a_factory_addr: assert property (
        (st_r.state == S_LOAD) && nv_blank |=> (slave_addr == FACTORY_ADDR) && !slave_en
        && !master_en) else $error("factory settings wrong");
    a_no_master: assert property (
        s_exec(OP_BRIDGE) ##0 !master_en |=> rep_valid && (rep_data == ST_NO_MASTER) && !br_start)
        else $error("bridge ran without master mode");
    a_bus_error: assert property (
        (st_r.state == S_BR) && br_done && br_err |=> rep_valid && (rep_data == ST_BUS_ERR))
        else $error("bus error not reported");
    a_reset_cmd: assert property (
        s_tx_last ##0 (st_r.rbuf[1] == OP_RESET) && (st_r.rbuf[0] == ST_OK)
        |=> sys_reset_req && (st_r.state == S_LOAD) ##1 cmd_ready) else $error("reset missed");
endmodule
`default_nettype wire

// ==== dv/urc_host_model.sv ====
// Purpose: Host side that sends command reports and collects the replies
// Assumes: Requests change only on the falling edge of ref_clk
// Notes: Reply ready drops on every third cycle to show a slow host
`default_nettype none
module urc_host_model (
    // Clock
    input wire logic ref_clk,
    // Command stream
    output logic cmd_valid,
    input wire logic cmd_ready,
    output logic [7:0] cmd_data,
    // Reply stream
    input wire logic rep_valid,
    output logic rep_ready,
    input wire logic [7:0] rep_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cmd [64];
    logic [7:0] rep [64];
    int tmo;

    // Idle levels before the first exchange
    initial
    begin
        cmd_valid = 1'b0;
        cmd_data = 8'h00;
        rep_ready = 1'b0;
    end

    // Whole report, each byte held until an edge sees ready
    task automatic send();
        for (int i = 0; i < 64; i++)
        begin
            @(negedge ref_clk);
            cmd_valid = 1'b1;
            cmd_data = cmd[i];
            tmo = 0;
            while (cmd_ready !== 1'b1 && tmo < 5000)
            begin
                @(negedge ref_clk);
                tmo++;
            end
        end
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        cmd_data = ~cmd[63]; // Released line must not echo the last byte
    endtask

    // Exactly one 64-byte reply per command
    task automatic recv();
        int n;
        n = 0;
        tmo = 0;
        while (n < 64 && tmo < 5000)
        begin
            @(negedge ref_clk);
            rep_ready = (tmo % 3) != 2;
            if (rep_valid === 1'b1 && rep_ready)
            begin
                rep[n] = rep_data;
                n++;
            end
            tmo++;
        end
        @(negedge ref_clk);
        rep_ready = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench of the report command handler
// Assumes: Bench models storage, bridge engine, pins and slave requests
// Notes: Version values are arbitrary
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import urc_pkg::*;
    localparam urc_ver_s FWV = '{major: 8'h02, minor: 8'h05, patch: 8'h09};
    localparam urc_ver_s LDV = '{major: 8'h01, minor: 8'h03, patch: 8'h07};
    logic ref_clk, resetn, cmd_valid, cmd_ready, rep_valid, rep_ready, nv_wr;
    logic nv_blank = 1'b1;
    logic [7:0] cmd_data, rep_data, slave_addr, slv_cmd_code, br_wdata, br_rdata, v, a;
    urc_cfg_s nv_cfg_out;
    urc_cfg_s nv_cfg_in = CFG_FACTORY;
    urc_br_req_s br_req, q_req;
    logic [2:0] port_on, gpio_in, gpio_out, gpio_oe_n, exp_d;
    logic gpio_if_en, loader_mode, sys_reset_req, slave_en, master_en, slv_cmd_valid;
    logic br_start, br_wvalid, br_wready, br_rvalid, br_done, br_err, err_mode;
    logic [31:0] seed = 32'he48017b9;
    logic [7:0] wq [$];
    logic [7:0] rq [$];
    int failures = 0;
    int n_checks = 0;
    int n_wr = 0;
    int n_rst = 0;
    int n_start = 0;
    logic [31:0] errs [8] = '{32'h30040000, 32'h41010200, 32'h41000100, 32'h51040000,
                              32'h61030000, 32'h77000000, 32'h52016a3d, 32'h52036a01};

    urc_cmd_handler #(.FW_VER(FWV), .LDR_VER(LDV)) dut (.ref_clk(ref_clk), .resetn(resetn),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data),
        .rep_valid(rep_valid), .rep_ready(rep_ready), .rep_data(rep_data),
        .nv_cfg_in(nv_cfg_in), .nv_blank(nv_blank), .nv_wr(nv_wr), .nv_cfg_out(nv_cfg_out),
        .port_on(port_on), .gpio_if_en(gpio_if_en), .loader_mode(loader_mode),
        .sys_reset_req(sys_reset_req), .slave_en(slave_en), .master_en(master_en),
        .slave_addr(slave_addr), .slv_cmd_valid(slv_cmd_valid), .slv_cmd_code(slv_cmd_code),
        .br_start(br_start), .br_req(br_req), .br_wvalid(br_wvalid), .br_wready(br_wready),
        .br_wdata(br_wdata), .br_rvalid(br_rvalid), .br_rdata(br_rdata), .br_done(br_done),
        .br_err(br_err), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n));
    urc_host_model host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_data(cmd_data), .rep_valid(rep_valid), .rep_ready(rep_ready),
        .rep_data(rep_data));

    // Clock at 25 MHz
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Pulse counters and the non-volatile store, which keeps each written setting
    always @(posedge ref_clk)
    begin
        n_wr += int'(nv_wr === 1'b1);
        n_rst += int'(sys_reset_req === 1'b1);
        if (nv_wr === 1'b1)
        begin
            nv_cfg_in <= nv_cfg_out;
            nv_blank <= 1'b0;
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected head of a plain reply
    function automatic logic [47:0] exp_echo(input logic [7:0] b0, b1, b2, input logic ok);
        if (!ok)
            return {ST_ERR, b0, 32'h0};
        if (b0 == OP_PIN_IF)
            return {ST_OK, b0, b1, 24'h0};
        if (b0 == OP_SER_CFG)
            return {ST_OK, b0, 32'h0};
        return {ST_OK, b0, b1, b2, 16'h0};
    endfunction

    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic do_reset();
        @(negedge ref_clk);
        resetn = 1'b0;
        repeat (8) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (3) @(negedge ref_clk);
    endtask

    // One exchange with four set bytes and random filler
    task automatic xfer(input logic [7:0] b0, b1, b2, b3);
        for (int i = 4; i < 64; i++)
            host.cmd[i] = 8'(rnd());
        host.cmd[0] = b0;
        host.cmd[1] = b1;
        host.cmd[2] = b2;
        host.cmd[3] = b3;
        host.send();
        host.recv();
    endtask

    task automatic chk_rep(input logic [47:0] e);
        logic [7:0] t;
        t = 8'h00;
        for (int i = 6; i < 64; i++)
            t |= host.rep[i];
        chk({host.rep[0], host.rep[1], host.rep[2], host.rep[3], host.rep[4], host.rep[5]},
            e, "reply head");
        chk(t, 8'h00, "reply tail");
    endtask

    // Bridge transfer and its reply
    task automatic bridge(input logic [7:0] act, n, input logic e);
        logic [7:0] ta;
        ta = 8'(rnd()) & 8'hfe;
        err_mode = e;
        xfer(OP_BRIDGE, act, ta, n);
        chk(q_req, {act == BR_READ, ta[7:1], n}, "request");
        chk({host.rep[0], host.rep[1], host.rep[2]}, {e ? ST_BUS_ERR : ST_OK, OP_BRIDGE, n},
            "bridge status");
        for (int i = 0; i < n; i++)
            chk(act == BR_READ ? host.rep[3 + i] : wq[i],
                act == BR_READ ? rq[i] : host.cmd[4 + i], "data");
        $display("bridge act %h n %0d done", act, n);
    endtask

    // Serial bridge engine: random write stalls, read data, then done
    initial
    begin
        int k;
        {br_wready, br_rvalid, br_done, br_err} = 4'h0;
        br_rdata = 8'h00;
        forever
        begin
            @(negedge ref_clk);
            if (br_start === 1'b1)
            begin
                q_req = br_req;
                n_start++;
                wq.delete();
                rq.delete();
                k = 0;
                while (!q_req.rd && wq.size() < q_req.len && k < 2000)
                begin
                    br_wready = 1'(rnd() >> 7);
                    if (br_wvalid === 1'b1 && br_wready)
                        wq.push_back(br_wdata);
                    @(negedge ref_clk);
                    k++;
                end
                br_wready = 1'b0;
                for (int i = 0; i < q_req.len && q_req.rd; i++)
                begin
                    br_rvalid = 1'b1;
                    br_rdata = 8'(rnd());
                    rq.push_back(br_rdata);
                    @(negedge ref_clk);
                end
                br_rvalid = 1'b0;
                br_rdata = ~br_rdata;
                br_done = 1'b1;
                br_err = err_mode;
                @(negedge ref_clk);
                br_done = 1'b0;
                br_err = 1'b0;
            end
        end
    end

    task automatic close_out();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        failures++;
        close_out();
    end

    // Main sequence
    initial
    begin
        {resetn, slv_cmd_valid, gpio_in, slv_cmd_code} = 13'h0;
        do_reset();
        chk({port_on, slave_en, master_en, slave_addr}, {5'h0, FACTORY_ADDR}, "boot");
        for (int k = 0; k < 3; k++)
        begin
            v = (k == 2) ? 8'h07 : 8'(1 - k);
            xfer(OP_PIN_IF, v, 8'(rnd()), 8'h00);
            chk_rep(exp_echo(OP_PIN_IF, v, 8'h00, k != 2));
            chk(gpio_if_en, k == 0, "pin if");
        end
        for (int p = 1; p <= 3; p++)
        begin
            v = 8'(rnd() & 1);
            xfer(OP_PIN_WR, 8'(p), v, 8'h00);
            chk_rep(exp_echo(OP_PIN_WR, 8'(p), v, 1'b1));
            chk({gpio_out[p - 1], gpio_oe_n[p - 1]}, {v[0], 1'b0}, "pin drive");
            gpio_in[p - 1] = ~v[0];
            xfer(OP_PIN_RD, 8'(p), 8'h00, 8'h00);
            chk_rep(exp_echo(OP_PIN_RD, 8'(p), {7'h0, ~v[0]}, 1'b1));
            v = 8'(rnd() & 1);
            exp_d[p - 1] = v[0];
            xfer(OP_DFLT, 8'(p), v, 8'h00);
            chk_rep(exp_echo(OP_DFLT, 8'(p), v, 1'b1));
        end
        chk({nv_cfg_out.dflt, 8'(n_wr)}, {exp_d, 8'h03}, "defaults");
        $display("pins and defaults done");
        a = 8'(rnd()) & 8'hfe;
        xfer(OP_SER_CFG, ACT_SLAVE, VAL_ON, 8'h00);
        chk_rep(exp_echo(OP_SER_CFG, 8'h00, 8'h00, 1'b1));
        xfer(OP_SER_CFG, ACT_MASTER, VAL_ON, 8'h00);
        xfer(OP_SER_CFG, ACT_ADDR, a, 8'h00);
        chk({slave_en, master_en, slave_addr, 8'(n_wr)}, {2'b11, a, 8'h06}, "serial");
        for (int k = 0; k < 2; k++)
        begin
            @(negedge ref_clk);
            slv_cmd_valid = 1'b1;
            slv_cmd_code = k == 0 ? SW_ALL_ON : SW_OFF_BASE + 8'h01;
            @(negedge ref_clk);
            slv_cmd_valid = 1'b0;
            repeat (2) @(negedge ref_clk);
            chk(port_on, k == 0 ? 3'h7 : 3'h5, "slave switch");
        end
        foreach (errs[k])
        begin
            xfer(errs[k][31:24], errs[k][23:16], errs[k][15:8], errs[k][7:0]);
            chk_rep(exp_echo(errs[k][31:24], 8'h00, 8'h00, 1'b0));
        end
        bridge(BR_WRITE, 8'h02, 1'b0);
        bridge(BR_WRITE, BR_WR_MAX, 1'b0);
        bridge(BR_READ, BR_RD_MAX, 1'b0);
        bridge(BR_READ, 8'h03, 1'b1);
        xfer(OP_SER_CFG, ACT_MASTER, VAL_OFF, 8'h00);
        xfer(OP_BRIDGE, BR_WRITE, 8'h20, 8'h01);
        chk({host.rep[0], host.rep[1], 8'(n_start)}, {ST_NO_MASTER, OP_BRIDGE, 8'h04},
            "no master");
        xfer(OP_VERSION, SUBJ_FW, 8'h00, 8'h00);
        chk_rep({ST_OK, OP_VERSION, FWV, 8'h00});
        xfer(OP_VERSION, SUBJ_LDR, 8'h00, 8'h00);
        chk_rep({ST_OK, OP_VERSION, LDV, 8'h00});
        xfer(OP_LOADER, 8'h00, 8'h00, 8'h00);
        chk_rep({ST_OK, OP_LOADER, 32'h0});
        chk(loader_mode, 1'b1, "loader");
        xfer(OP_RESET, 8'h00, 8'h00, 8'h00);
        chk_rep({ST_OK, OP_RESET, 32'h0});
        repeat (3) @(negedge ref_clk);
        chk({8'(n_rst), loader_mode}, {8'h01, 1'b0}, "board reset");
        do_reset();
        chk({port_on, slave_en, master_en, slave_addr}, {exp_d, 2'b10, a}, "restore");
        $display("serial, bridge and control done");
        close_out();
    end
endmodule
`default_nettype wire
